//--- fsk_pkg.sv
// package for the flash security key and margin command sequencer
// assumes a 32-bit avalon-mm slave with word addressing on byte addresses
package fsk_pkg;
  // byte offsets of the register map
  localparam logic [5:0] OFS_SECURITY   = 6'h00;
  localparam logic [5:0] OFS_STATUS     = 6'h04;
  localparam logic [5:0] OFS_PARAM_IDX  = 6'h08;
  localparam logic [5:0] OFS_PARAM_WORD = 6'h0C;
  localparam logic [5:0] OFS_IRQ_STAT   = 6'h10;
  localparam logic [5:0] OFS_IRQ_MASK   = 6'h14;
  localparam logic [5:0] OFS_MARGIN     = 6'h18;
  // field positions
  localparam int COMMAND_COMPLETE_FLAG_BIT   = 7;
  localparam int ACCESS_ERROR_FLAG_BIT = 5;
  localparam int UNSEC_BIT  = 0;
  // decoded patterns
  localparam logic [1:0] KEY_ENABLED  = 2'h2;
  localparam logic [1:0] SEC_UNSECURE = 2'h2;
  // commands and launch index values
  localparam logic [7:0] CMD_VERIFY_KEY = 8'h0C;
  localparam logic [7:0] CMD_SET_MARGIN = 8'h0D;
  localparam logic [2:0] IDX_VERIFY_KEY = 3'h4;
  localparam logic [2:0] IDX_SET_MARGIN = 3'h2;
  // default block address of the eeprom, upper byte
  localparam logic [7:0] EEPROM_ADDR_HI = 8'h10;
  localparam int         CMD_CYCLES     = 4;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CHECK = 2'b01,
    ST_EXEC  = 2'b11,
    ST_DONE  = 2'b10
  } fsk_state_e;
  typedef struct packed {
    logic [1:0] backdoorEnable;
    logic [3:0] reservedNv;
    logic [1:0] securityState;
  } fsk_secbyte_s;
  typedef struct packed {
    logic [1:0] irqStat;
    logic [1:0] irqMask;
  } fsk_irq_s;
endpackage

//--- fsk_flash_cmd.sv
// command sequencer: security decode, backdoor key verify, set user margin level
// assumes the nonvolatile security byte and stored keys are stable inputs on clk
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
module fsk_flash_cmd
  import fsk_pkg::*;
#(
  parameter int KEY_WORDS = 4
) (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic [5:0]             avsAddress,
  input  wire logic                   avsRead,
  input  wire logic                   avsWrite,
  input  wire logic [31:0]            avsWriteData,
  input  wire logic [3:0]             avsByteEnable,
  output logic [31:0]                 avsReadData,
  output logic                        avsWaitRequest,
  input  wire fsk_secbyte_s           nvSecurityByte,
  input  wire logic [KEY_WORDS*16-1:0] storedKey,
  output logic [15:0]                 pflashMarginLevel,
  output logic [15:0]                 eepromMarginLevel,
  output logic                        irq
);
  initial begin
    if (KEY_WORDS < 1 || KEY_WORDS > 7) begin
      $error("KEY_WORDS must be 1 to 7");
    end
  end

  typedef struct packed {
    fsk_state_e state;
    logic       command_complete_flag;
    logic       access_error_flag;
    logic       unlocked;
    logic       lockout;
    logic [2:0] paramIdx;
    logic [7:0][15:0] words;
    logic [15:0] pfMargin;
    logic [15:0] eeMargin;
    fsk_irq_s   irqRegs;
    logic [2:0] cnt;
    logic        rdAck;
    logic [31:0] rdData;
  } fsk_regs_s;

  fsk_regs_s r_q;
  fsk_regs_s r_d;
  logic      keyEnabled;
  logic      keyMatch;
  logic [1:0] secShown;
  logic [31:0] rdMux;
  logic       acc;

  assign keyEnabled = (nvSecurityByte.backdoorEnable == KEY_ENABLED);
  // unlock overrides the nonvolatile pattern
  assign secShown = r_q.unlocked ? SEC_UNSECURE : nvSecurityByte.securityState;

  always_comb begin
    keyMatch = 1'b1;
    for (int i = 0; i < KEY_WORDS; i++) begin
      if (r_q.words[i+1] != storedKey[i*16 +: 16]) begin
        keyMatch = 1'b0;
      end
    end
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (avsAddress)
      OFS_SECURITY: rdMux = {22'h0, (secShown == SEC_UNSECURE), 1'b0, nvSecurityByte.backdoorEnable,
                             nvSecurityByte.reservedNv, secShown};
      OFS_STATUS:   rdMux = {24'h0, r_q.command_complete_flag, 1'b0, r_q.access_error_flag, 5'h0};
      OFS_PARAM_IDX: rdMux = {29'h0, r_q.paramIdx};
      OFS_PARAM_WORD: rdMux = {16'h0, r_q.words[r_q.paramIdx]};
      OFS_IRQ_STAT: rdMux = {30'h0, r_q.irqRegs.irqStat};
      OFS_IRQ_MASK: rdMux = {30'h0, r_q.irqRegs.irqMask};
      OFS_MARGIN:   rdMux = {r_q.eeMargin, r_q.pfMargin};
      default:      rdMux = 32'h0000_0000;
    endcase
  end

  // one wait cycle on reads so data comes from a flop; writes complete at once
  assign avsWaitRequest = avsRead & ~r_q.rdAck;
  assign acc = avsWrite & avsByteEnable[0];

  always_comb begin
    r_d = r_q;
    r_d.rdAck = avsRead & ~r_q.rdAck;
    if (avsRead & ~r_q.rdAck) begin
      r_d.rdData = rdMux;
    end
    if (acc) begin
      unique case (avsAddress)
        OFS_STATUS: begin
          if (avsWriteData[ACCESS_ERROR_FLAG_BIT]) begin
            r_d.access_error_flag = 1'b0;
          end
          // writing one to the complete flag clears it and launches
          if (avsWriteData[COMMAND_COMPLETE_FLAG_BIT] && r_q.command_complete_flag) begin
            r_d.command_complete_flag  = 1'b0;
            r_d.state = ST_CHECK;
          end
        end
        OFS_PARAM_IDX: if (r_q.command_complete_flag) r_d.paramIdx = avsWriteData[2:0];
        OFS_PARAM_WORD: if (r_q.command_complete_flag && avsByteEnable[1]) begin
          r_d.words[r_q.paramIdx] = avsWriteData[15:0];
        end
        OFS_IRQ_STAT: r_d.irqRegs.irqStat = r_q.irqRegs.irqStat & ~avsWriteData[1:0];
        OFS_IRQ_MASK: r_d.irqRegs.irqMask = avsWriteData[1:0];
        default: ;
      endcase
    end
    unique case (r_q.state)
      ST_IDLE: ;
      ST_CHECK: begin
        r_d.cnt   = 3'(CMD_CYCLES - 1);
        r_d.state = ST_EXEC;
        if (r_q.words[0][15:8] == CMD_VERIFY_KEY) begin
          if (!keyEnabled || r_q.lockout || r_q.paramIdx != IDX_VERIFY_KEY) begin
            r_d.access_error_flag = 1'b1;
            r_d.state  = ST_DONE;
          end
        end else if (r_q.words[0][15:8] == CMD_SET_MARGIN) begin
          if (r_q.paramIdx != IDX_SET_MARGIN) begin
            r_d.access_error_flag = 1'b1;
            r_d.state  = ST_DONE;
          end
        end else begin
          r_d.access_error_flag = 1'b1;
          r_d.state  = ST_DONE;
        end
      end
      ST_EXEC: begin
        r_d.cnt = r_q.cnt - 3'h1;
        if (r_q.cnt == 3'h0) begin
          r_d.state = ST_DONE;
          if (r_q.words[0][15:8] == CMD_VERIFY_KEY) begin
            if (keyMatch) begin
              r_d.unlocked = 1'b1;
            end else begin
              r_d.lockout = 1'b1;
              r_d.access_error_flag  = 1'b1;
            end
          end else begin
            // eeprom target: eeprom only; flash target: both arrays
            if (r_q.words[0][7:0] == EEPROM_ADDR_HI) begin
              r_d.eeMargin = r_q.words[2];
            end else begin
              r_d.pfMargin = r_q.words[2];
              r_d.eeMargin = r_q.words[2];
            end
          end
        end
      end
      ST_DONE: begin
        r_d.command_complete_flag  = 1'b1;
        r_d.state = ST_IDLE;
      end
      default: r_d.state = ST_IDLE;
    endcase
    // sticky events: set wins over a clear in the same cycle
    if (r_q.state == ST_DONE) begin
      r_d.irqRegs.irqStat[0] = 1'b1;
    end
    if (r_d.access_error_flag && !r_q.access_error_flag) begin
      r_d.irqRegs.irqStat[1] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_q          <= '0;
      r_q.state    <= ST_IDLE;
      r_q.command_complete_flag     <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign avsReadData       = r_q.rdData;
  assign pflashMarginLevel = r_q.pfMargin;
  assign eepromMarginLevel = r_q.eeMargin;
  assign irq = |(r_q.irqRegs.irqStat & r_q.irqRegs.irqMask);
endmodule

//--- fsk_assertions.sv
// checker of bus timing, index view, key field view and margin spread
// assumes a bind onto the ports of fsk_flash_cmd
`timescale 1ns/1ps
module fsk_assertions
  import fsk_pkg::*;
(
  input wire logic         clk,
  input wire logic         arst_n,
  input wire logic [5:0]   avsAddress,
  input wire logic         avsRead,
  input wire logic         avsWrite,
  input wire logic [31:0]  avsReadData,
  input wire logic         avsWaitRequest,
  input wire fsk_secbyte_s nvSecurityByte,
  input wire logic [15:0]  pflashMarginLevel,
  input wire logic [15:0]  eepromMarginLevel,
  input wire logic         irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic rdEnd = avsRead && !avsWaitRequest;
  first_wait_a: assert property ($rose(avsRead) |-> avsWaitRequest) else $error("no wait");
  read_answer_a: assert property (avsRead && avsWaitRequest |=> !avsWaitRequest)
    else $error("late read");
  write_nowait_a: assert property (avsWrite |-> !avsWaitRequest) else $error("write held");
  idle_nowait_a: assert property (!avsRead |-> !avsWaitRequest) else $error("stray wait");
  idx_zero_a: assert property (rdEnd && avsAddress == OFS_PARAM_IDX |-> avsReadData[31:3] == 0)
    else $error("index high bits set");
  unmapped_zero_a: assert property (rdEnd && avsAddress == 6'h1C |-> avsReadData == 0)
    else $error("unmapped read not zero");
  backdoor_enable_field_view_a: assert property (rdEnd && avsAddress == OFS_SECURITY |->
    avsReadData[7:6] == nvSecurityByte.backdoorEnable) else $error("key field wrong");
  margin_both_a: assert property ($changed(pflashMarginLevel) |->
    eepromMarginLevel == pflashMarginLevel) else $error("pflash level alone");
  cover property (rdEnd && avsAddress == OFS_STATUS);
  cover property ($rose(irq));
  cover property ($changed(eepromMarginLevel));
endmodule

//--- fsk_flash_cmd_tb.sv
// self-checking bench: key verify, lockout, margins, irq, random keys
// assumes reads answer after a wait cycle and writes land at once
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module fsk_flash_cmd_tb
  import fsk_pkg::*;
;
  logic         clk = 0, arst_n = 0, rd = 0, wr = 0, irq, ws, wreq;
  logic [5:0]   addr = 0;
  logic [31:0]  wd = 0, rdat, q;
  logic [15:0]  pf, ee, lvl, pfExp = 0;
  logic [15:0]  pw[8];
  logic [63:0]  key;
  fsk_secbyte_s sec = 8'h00;
  int           seed = 32'he02d, fail_count = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  fsk_flash_cmd dut (.clk(clk), .arst_n(arst_n), .avsAddress(addr), .avsRead(rd),
    .avsWrite(wr), .avsWriteData(wd), .avsByteEnable(4'hF), .avsReadData(rdat),
    .avsWaitRequest(wreq), .nvSecurityByte(sec), .storedKey(key),
    .pflashMarginLevel(pf), .eepromMarginLevel(ee), .irq(irq));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic rst();
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
  endtask
  // wait and data are read at the rising edge, before the flops update
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
      ws = wreq;
      q = rdat;
    end while (ws && n < 20);
    if (ws) fail_count++;
    if (ws) report_and_stop();
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cmd(input int last, input logic err);
    for (int i = 0; i <= last; i++) begin
      bus(1, OFS_PARAM_IDX, i);
      bus(1, OFS_PARAM_WORD, {16'h0, pw[i]});
    end
    bus(1, OFS_STATUS, 32'hA0);
    bus(0, OFS_STATUS, 0);
    if (!err) `CHK("busy", 1'b0, q[COMMAND_COMPLETE_FLAG_BIT])
    for (int n = 0; n < 20 && q[COMMAND_COMPLETE_FLAG_BIT] !== 1'b1; n++) bus(0, OFS_STATUS, 0);
    `CHK("complete", 1'b1, q[COMMAND_COMPLETE_FLAG_BIT])
    `CHK("access error", err, q[ACCESS_ERROR_FLAG_BIT])
  endtask
  initial begin
    key = {$random(seed), $random(seed)};
    rst();
    bus(0, OFS_STATUS, 0);
    `CHK("reset status", 2'b10, {q[COMMAND_COMPLETE_FLAG_BIT], q[ACCESS_ERROR_FLAG_BIT]})
    bus(1, OFS_PARAM_IDX, 32'hFFFF_FFFF);
    bus(0, OFS_PARAM_IDX, 0);
    `CHK("index", 32'h7, q)
    bus(0, 6'h1C, 0);
    `CHK("unmapped", 32'h0, q)
    pw[0] = {CMD_VERIFY_KEY, 8'h00};
    for (int i = 1; i < 5; i++) pw[i] = key[i*16-16 +: 16];
    for (int k = 0; k < 4; k++) if (k != 2) begin
      sec <= {k[1:0], 6'h00};
      cmd(4, 1'b1);
    end
    `CHK("irq masked", 1'b0, irq)
    sec <= 8'h80;
    cmd(3, 1'b1);
    cmd(4, 1'b0);
    bus(0, OFS_SECURITY, 0);
    `CHK("unsecured", SEC_UNSECURE, q[1:0])
    bus(1, OFS_IRQ_MASK, 3);
    `CHK("irq", 1'b1, irq)
    bus(1, OFS_IRQ_STAT, 3);
    `CHK("irq clear", 1'b0, irq)
    for (int j = 0; j < 2; j++) begin
      lvl = $random(seed);
      pw[0] = {CMD_SET_MARGIN, j ? EEPROM_ADDR_HI : 8'h00};
      pw[1] = $random(seed);
      pw[2] = lvl;
      cmd(2, 1'b0);
      if (j == 0) pfExp = lvl;
      `CHK("eeprom level", lvl, ee)
      `CHK("pflash level", pfExp, pf)
    end
    // bad key, then good key still refused, then reset lifts the lockout
    pw[0] = {CMD_VERIFY_KEY, 8'h00};
    for (int m = 0; m < 3; m++) begin
      if (m != 1) rst();
      for (int i = 1; i < 5; i++) pw[i] = key[i*16-16 +: 16] ^ 16'(m == 0);
      cmd(4, m < 2);
    end
    report_and_stop();
  end
endmodule
bind fsk_flash_cmd fsk_assertions chk (.clk(clk), .arst_n(arst_n), .avsAddress(avsAddress),
  .avsRead(avsRead), .avsWrite(avsWrite), .avsReadData(avsReadData),
  .avsWaitRequest(avsWaitRequest), .nvSecurityByte(nvSecurityByte),
  .pflashMarginLevel(pflashMarginLevel), .eepromMarginLevel(eepromMarginLevel), .irq(irq));
